// ==== lcv_ctrl_pkg.sv ====
// Constants and carrier types for the counter global control register bank
package lcv_ctrl_pkg;
	// Register offsets on the microprocessor register port
	localparam logic [7:0] ADDR_LINE_SOURCE_CONTROL = 8'h82;
	localparam logic [7:0] ADDR_VIOLATION_COUNTER_CHANNEL_SELECT = 8'h8C;
	localparam logic [7:0] ADDR_VIOLATION_COUNTER_CONTROL = 8'h8D;
	localparam logic [7:0] ADDR_VIOLATION_COUNT_BYTE = 8'h8E;
	// Field positions in the source control register
	localparam int TX_SRC_BIT = 7;
	localparam int TERM_SRC_BIT = 6;
	// Field positions in the counter control register
	localparam int CLEAR_ALL_BIT = 4;
	localparam int LATCH_ALL_BIT = 3;
	localparam int BYTE_PICK_BIT = 2;
	localparam int LATCH_ONE_BIT = 1;
	localparam int CLEAR_ONE_BIT = 0;
	// Channel select field
	localparam int SEL_MSB = 3;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_FIRST = 4'h1;
	localparam logic [3:0] SEL_LAST = 4'h8;
	// Sizes
	localparam int NUM_CHANNELS = 8;
	localparam int COUNT_WIDTH = 16;
	// Reset values and counter increment
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	// Least hold time of a clear bit, kept by software
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLEAR_HOLD_NS = 1000;
	localparam int CLEAR_HOLD_CYCLES = (CLEAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Source control bits
	typedef struct packed {
		logic tx_enable_source_sel;
		logic rx_term_source_sel;
	} source_ctrl_t;

	// Counter control bits
	typedef struct packed {
		logic all_counters_clear;
		logic all_counters_latch;
		logic count_byte_pick;
		logic one_counter_latch;
		logic one_counter_clear;
	} counter_ctrl_t;

	// One register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// ==== lcv_counter_global_control.sv ====
// Global line source control and line code violation counter bank
`timescale 1ns/100ps
module lcv_counter_global_control
	import lcv_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire reg_req_t reg_req,
	input wire logic host_mode,
	input wire logic tx_drive_on,
	input wire logic tx_drive_on_global,
	input wire logic [NUM_CHANNELS-1:0] tx_drive_on_chan,
	input wire logic rx_term_select,
	input wire logic [NUM_CHANNELS-1:0] rx_term_select_chan,
	input wire logic [NUM_CHANNELS-1:0] line_code_violation,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic [NUM_CHANNELS-1:0] tx_enable,
	output logic [NUM_CHANNELS-1:0] rx_term_enable
);

	// Stored control fields
	source_ctrl_t src_q;
	source_ctrl_t src_d;
	logic [3:0] sel_q;
	logic [3:0] sel_d;
	counter_ctrl_t cnt_ctrl_q;
	counter_ctrl_t cnt_ctrl_d;
	// Read answer
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	// Line controls
	logic [NUM_CHANNELS-1:0] tx_q;
	logic [NUM_CHANNELS-1:0] tx_d;
	logic [NUM_CHANNELS-1:0] term_q;
	logic [NUM_CHANNELS-1:0] term_d;
	// Per-channel counters and holding registers
	logic [COUNT_WIDTH-1:0] count_q [NUM_CHANNELS];
	logic [COUNT_WIDTH-1:0] hold_q [NUM_CHANNELS];
	// One-hot decode of the select field
	logic [NUM_CHANNELS-1:0] sel_hot;
	// Latch strobes, one cycle on the write that sets the bit
	logic latch_all_pulse;
	logic latch_one_pulse;
	// Holding word of the selected channel
	logic [COUNT_WIDTH-1:0] sel_hold;
	// Write strobes per register
	logic wr_src;
	logic wr_sel;
	logic wr_ctrl;

	assign wr_src = reg_req.wr && (reg_req.addr == ADDR_LINE_SOURCE_CONTROL);
	assign wr_sel = reg_req.wr && (reg_req.addr == ADDR_VIOLATION_COUNTER_CHANNEL_SELECT);
	assign wr_ctrl = reg_req.wr && (reg_req.addr == ADDR_VIOLATION_COUNTER_CONTROL);

	// Register writes; reserved bits are not stored
	always_comb
	begin
		src_d = src_q;
		sel_d = sel_q;
		cnt_ctrl_d = cnt_ctrl_q;
		if (wr_src)
		begin
			src_d.tx_enable_source_sel = reg_req.wdata[TX_SRC_BIT];
			src_d.rx_term_source_sel = reg_req.wdata[TERM_SRC_BIT];
		end
		if (wr_sel)
		begin
			sel_d = reg_req.wdata[SEL_MSB:0];
		end
		if (wr_ctrl)
		begin
			cnt_ctrl_d.all_counters_clear = reg_req.wdata[CLEAR_ALL_BIT];
			cnt_ctrl_d.all_counters_latch = reg_req.wdata[LATCH_ALL_BIT];
			cnt_ctrl_d.count_byte_pick = reg_req.wdata[BYTE_PICK_BIT];
			cnt_ctrl_d.one_counter_latch = reg_req.wdata[LATCH_ONE_BIT];
			cnt_ctrl_d.one_counter_clear = reg_req.wdata[CLEAR_ONE_BIT];
		end
	end

	// Control registers
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			src_q <= '0;
			sel_q <= SEL_NONE;
			cnt_ctrl_q <= '0;
		end
		else
		begin
			src_q <= src_d;
			sel_q <= sel_d;
			cnt_ctrl_q <= cnt_ctrl_d;
		end
	end

	// Latch fires on the write that turns the bit from zero to one;
	// holding it at one does not keep refreshing, so reads stay stable
	always_comb
	begin
		latch_all_pulse = wr_ctrl && reg_req.wdata[LATCH_ALL_BIT] && !cnt_ctrl_q.all_counters_latch;
		latch_one_pulse = wr_ctrl && reg_req.wdata[LATCH_ONE_BIT] && !cnt_ctrl_q.one_counter_latch;
	end

	// Select decode: code n picks channel n-1, out-of-range picks none
	always_comb
	begin
		sel_hot = '0;
		sel_hold = COUNT_ZERO;
		if (sel_q >= SEL_FIRST && sel_q <= SEL_LAST)
		begin
			sel_hot[3'(sel_q - SEL_FIRST)] = 1'b1;
			sel_hold = hold_q[3'(sel_q - SEL_FIRST)];
		end
	end

	// Per-channel counter and holding register
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++)
		begin : g_chan
			logic [COUNT_WIDTH-1:0] count_d;
			logic [COUNT_WIDTH-1:0] hold_d;

			// Next counter and holding values
			always_comb
			begin
				count_d = count_q[ch];
				hold_d = hold_q[ch];
				if (cnt_ctrl_q.all_counters_clear)
				begin
					count_d = COUNT_ZERO;
				end
				else if (cnt_ctrl_q.one_counter_clear && sel_hot[ch])
				begin
					count_d = COUNT_ZERO;
				end
				else if (line_code_violation[ch])
				begin
					count_d = count_q[ch] + COUNT_ONE;
				end
				if (latch_all_pulse)
				begin
					hold_d = count_q[ch];
				end
				else if (latch_one_pulse && sel_hot[ch])
				begin
					hold_d = count_q[ch];
				end
			end

			// Counter state
			always_ff @(posedge clk_sys or negedge resetn)
			begin
				if (!resetn)
				begin
					count_q[ch] <= COUNT_ZERO;
					hold_q[ch] <= COUNT_ZERO;
				end
				else
				begin
					count_q[ch] <= count_d;
					hold_q[ch] <= hold_d;
				end
			end
		end
	endgenerate

	// Transmit and termination source muxing per channel
	always_comb
	begin
		if (src_q.tx_enable_source_sel)
		begin
			tx_d = tx_drive_on_chan;
		end
		else if (host_mode)
		begin
			tx_d = {NUM_CHANNELS{tx_drive_on_global}};
		end
		else
		begin
			tx_d = {NUM_CHANNELS{tx_drive_on}};
		end
		if (src_q.rx_term_source_sel)
		begin
			term_d = {NUM_CHANNELS{rx_term_select}};
		end
		else if (host_mode)
		begin
			term_d = rx_term_select_chan;
		end
		else
		begin
			term_d = {NUM_CHANNELS{rx_term_select}};
		end
	end

	// Line control outputs, registered so the pins never glitch
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_q <= '0;
			term_q <= '0;
		end
		else
		begin
			tx_q <= tx_d;
			term_q <= term_d;
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb
	begin
		rdata_d = DATA_ZERO;
		rvalid_d = reg_req.rd;
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				ADDR_LINE_SOURCE_CONTROL:
				begin
					rdata_d[TX_SRC_BIT] = src_q.tx_enable_source_sel;
					rdata_d[TERM_SRC_BIT] = src_q.rx_term_source_sel;
				end
				ADDR_VIOLATION_COUNTER_CHANNEL_SELECT:
				begin
					rdata_d[SEL_MSB:0] = sel_q;
				end
				ADDR_VIOLATION_COUNTER_CONTROL:
				begin
					rdata_d[CLEAR_ALL_BIT] = cnt_ctrl_q.all_counters_clear;
					rdata_d[LATCH_ALL_BIT] = cnt_ctrl_q.all_counters_latch;
					rdata_d[BYTE_PICK_BIT] = cnt_ctrl_q.count_byte_pick;
					rdata_d[LATCH_ONE_BIT] = cnt_ctrl_q.one_counter_latch;
					rdata_d[CLEAR_ONE_BIT] = cnt_ctrl_q.one_counter_clear;
				end
				ADDR_VIOLATION_COUNT_BYTE:
				begin
					rdata_d = cnt_ctrl_q.count_byte_pick ? sel_hold[15:8] : sel_hold[7:0];
				end
				default:
				begin
					rdata_d = DATA_ZERO;
				end
			endcase
		end
	end

	// Read answer registers
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= DATA_ZERO;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign tx_enable = tx_q;
	assign rx_term_enable = term_q;

endmodule

// ==== lcv_counter_global_control_chk.sv ====
// Port checker for the counter control bank
`timescale 1ns/100ps
module lcv_counter_global_control_chk
	import lcv_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire reg_req_t reg_req,
	input wire logic host_mode,
	input wire logic tx_drive_on,
	input wire logic tx_drive_on_global,
	input wire logic [7:0] tx_drive_on_chan,
	input wire logic rx_term_select,
	input wire logic [7:0] rx_term_select_chan,
	input wire logic [7:0] line_code_violation,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [7:0] tx_enable,
	input wire logic [7:0] rx_term_enable
);
	// Shadow of the two source bits
	logic [1:0] src_q, src_d;
	// Follows host writes so the body stays hidden
	always_comb
		src_d = (reg_req.wr && reg_req.addr == 8'h82) ? reg_req.wdata[7:6] : src_q;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
			src_q <= 2'h0;
		else
			src_q <= src_d;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
		else $error("no read answer");
	a_no_stray_answer: assert property (!reg_req.rd |=> !reg_rvalid)
		else $error("read answer without request");
	a_tx_per_chan: assert property ($past(resetn) && $past(src_q[1]) |-> tx_enable == $past(tx_drive_on_chan))
		else $error("tx not per channel");
	a_tx_pin_ctl: assert property ($past(resetn) && !$past(src_q[1]) && !$past(host_mode)
		|-> tx_enable == {8{$past(tx_drive_on)}})
		else $error("tx not from pin");
	a_tx_global_ctl: assert property ($past(resetn) && !$past(src_q[1]) && $past(host_mode)
		|-> tx_enable == {8{$past(tx_drive_on_global)}})
		else $error("tx not from global bit");
	a_term_pin_ctl: assert property ($past(resetn) && ($past(src_q[0]) || !$past(host_mode))
		|-> rx_term_enable == {8{$past(rx_term_select)}})
		else $error("term not from pin");
	a_term_chan_ctl: assert property ($past(resetn) && !$past(src_q[0]) && $past(host_mode)
		|-> rx_term_enable == $past(rx_term_select_chan))
		else $error("term not per channel");
	a_src_readback: assert property (reg_req.rd && reg_req.addr == 8'h82 |=> reg_rdata == {$past(src_q), 6'h00})
		else $error("source readback");
	a_unmapped_zero: assert property (reg_req.rd && !(reg_req.addr inside {8'h82, 8'h8C, 8'h8D, 8'h8E})
		|=> reg_rvalid && reg_rdata == 8'h00)
		else $error("unmapped read");
endmodule
bind lcv_counter_global_control lcv_counter_global_control_chk u_chk (.clk_sys, .resetn, .reg_req, .host_mode,
	.tx_drive_on, .tx_drive_on_global, .tx_drive_on_chan, .rx_term_select, .rx_term_select_chan,
	.line_code_violation, .reg_rdata, .reg_rvalid, .tx_enable, .rx_term_enable);

// ==== tb_lcv_counter_global_control.sv ====
// Self-checking bench for the counter control bank
`timescale 1ns/100ps
module tb_lcv_counter_global_control;
	import lcv_ctrl_pkg::*;
	logic clk_sys, resetn, host_mode, tx_drive_on, tx_drive_on_global, rx_term_select, reg_rvalid;
	logic [7:0] tx_drive_on_chan = 8'h5A, rx_term_select_chan = 8'hC3;
	logic [7:0] line_code_violation, reg_rdata, tx_enable, rx_term_enable;
	reg_req_t reg_req;
	int error_cnt = 0, total_checks = 0;
	lcv_counter_global_control u_dut (.clk_sys, .resetn, .reg_req, .host_mode, .tx_drive_on, .tx_drive_on_global,
		.tx_drive_on_chan, .rx_term_select, .rx_term_select_chan, .line_code_violation, .reg_rdata, .reg_rvalid,
		.tx_enable, .rx_term_enable);
	initial
	begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input logic [15:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One port cycle, held for exactly one sampling edge
	task bus(input logic r, input logic [7:0] a, d);
		@(posedge clk_sys);
		#1 reg_req = '{!r, r, a, d};
		@(posedge clk_sys);
		#1 reg_req = '0;
	endtask
	task rd(input logic [7:0] a, e);
		bus(1, a, 8'h00);
		chk({reg_rvalid, reg_rdata}, {1'b1, e});
	endtask
	// Gap after each pulse in case counting is edge based
	task pulse(input logic [7:0] v);
		line_code_violation = v;
		@(posedge clk_sys);
		#1 line_code_violation = 8'h00;
		@(posedge clk_sys);
		#1;
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task t_regs;
		logic [7:0] a[3] = '{8'h82, 8'h8C, 8'h8D};
		logic [7:0] m[3] = '{8'hC0, 8'h0F, 8'h1F};
		for (int i = 0; i < 3; i++)
		begin
			rd(a[i], 8'h00);
			bus(0, a[i], 8'hFF);
			rd(a[i], m[i]);
			bus(0, a[i], 8'h00);
		end
		rd(8'h90, 8'h00);
	endtask
	// Every source, mode and pin level; pin and global differ
	task t_line;
		for (int i = 0; i < 16; i++)
		begin
			bus(0, 8'h82, {i[3:2], 6'h00});
			{host_mode, tx_drive_on} = i[1:0];
			{tx_drive_on_global, rx_term_select} = {2{!i[0]}};
			{tx_drive_on_chan, rx_term_select_chan} = {8'h5A, 8'hC3} ^ {16{i[0]}};
			repeat (2) @(posedge clk_sys);
			#1 chk(tx_enable, i[3] ? tx_drive_on_chan : {8{i[1] ^ i[0]}});
			chk(rx_term_enable, !i[2] && i[1] ? rx_term_select_chan : {8{!i[0]}});
		end
	endtask
	// Channel c gets 257+c counts, so low byte of select s is s
	task t_count;
		logic [7:0] v;
		for (int k = 0; k < 264; k++)
		begin
			for (int c = 0; c < 8; c++)
				v[c] = k < 257 + c;
			pulse(v);
		end
		bus(0, 8'h8D, 8'h08);
		for (int s = 0; s < 9; s++)
		begin
			bus(0, 8'h8C, s[7:0]);
			rd(8'h8E, s[7:0]);
		end
		bus(0, 8'h8D, 8'h0C);
		rd(8'h8E, 8'h01);
	endtask
	// Clear bit held 102 cycles, then a fresh latch of all
	task hold_clear(input logic [7:0] v);
		bus(0, 8'h8D, v);
		repeat (100) @(posedge clk_sys);
		bus(0, 8'h8D, 8'h00);
		bus(0, 8'h8D, 8'h08);
	endtask
	task t_single;
		bus(0, 8'h8D, 8'h00);
		repeat (8) pulse(8'h14);
		bus(0, 8'h8C, 8'h03);
		bus(0, 8'h8D, 8'h02);
		rd(8'h8E, 8'h0B);
		bus(0, 8'h8C, 8'h05);
		rd(8'h8E, 8'h05);
		bus(0, 8'h8C, 8'h03);
		hold_clear(8'h01);
		rd(8'h8E, 8'h00);
		bus(0, 8'h8C, 8'h05);
		rd(8'h8E, 8'h0D);
		hold_clear(8'h10);
		rd(8'h8E, 8'h00);
	endtask
	initial
	begin
		reg_req = '0;
		line_code_violation = 8'h00;
		{host_mode, tx_drive_on, tx_drive_on_global, rx_term_select, resetn} = 5'h00;
		repeat (4) @(posedge clk_sys);
		#1 resetn = 1;
		t_regs;
		t_line;
		t_count;
		t_single;
		wrap_up;
	end
	// Watchdog far past the roughly 9 us sequence
	initial
	begin
		#200000;
		error_cnt++;
		wrap_up;
	end
endmodule
